// ===== rtl/subword_pkg.sv
// Shared types and constants for the sub-word integer datapath.
// Assumes a 32-bit big-endian core with one clock and special registers numbered by 8 bits.
package subword_pkg;

    // Word geometry
    localparam int WORD_BITS = 32;
    localparam int HALF_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int LANES = 4;

    // Special register numbers
    localparam logic [7:0] SR_ALU_STATUS = 8'h84;
    localparam logic [7:0] SR_BYTE_POINTER = 8'h85;
    localparam logic [7:0] SR_FUNNEL_COUNT = 8'h86;

    // ALU status field layout
    localparam int ALU_BP_LSB = 5;
    localparam int ALU_FC_LSB = 0;
    localparam int BP_BITS = 2;
    localparam int FC_BITS = 5;

    // Reset values and fixed codes
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic [4:0] FC_RESET = 5'h00;
    localparam logic [1:0] BP_SIGN_SET = 2'h3;
    localparam logic [31:0] BOOL_TRUE = 32'h8000_0000;
    localparam logic [31:0] BOOL_FALSE = 32'h0000_0000;

    // Operations steered by the decoder
    typedef enum logic [3:0] {
        OP_NONE,
        OP_LOAD_BYTE,
        OP_LOAD_HALF,
        OP_STORE_BYTE,
        OP_STORE_HALF,
        OP_EXTRACT_BYTE,
        OP_INSERT_BYTE,
        OP_COMPARE_ANY_BYTE,
        OP_EXTRACT_HALF,
        OP_EXTRACT_HALF_S,
        OP_INSERT_HALF,
        OP_LOAD_LOW_IMM,
        OP_LOAD_HIGH_IMM,
        OP_LOAD_NEG_IMM,
        OP_BRANCH_COND
    } dp_op_t;

    // One decoded instruction with its operands
    typedef struct packed {
        logic valid;
        dp_op_t op;
        logic [31:0] dest_value;
        logic [31:0] src_value;
        logic use_imm8;
        logic [7:0] imm8;
        logic [15:0] imm16;
        logic [1:0] addr_low;
        logic sign_extend_select;
        logic [31:0] mem_word;
    } dp_request_t;

    // Special register move request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] number;
        logic [31:0] wdata;
    } sr_request_t;

    // Registered answer of the datapath
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [31:0] store_word;
        logic [3:0] store_lanes;
        logic branch_taken;
    } dp_result_t;

    // Whole state of the datapath
    typedef struct packed {
        logic [1:0] byte_pointer;
        logic [4:0] funnel_shift_count;
        dp_result_t res;
        logic [31:0] sr_rdata;
    } dp_state_t;

endpackage : subword_pkg

// ===== rtl/subword_datapath.sv
// Sub-word integer datapath: byte/half-word load, store, extract, insert, compare and constants.
// Assumes the decoder supplies one request per cycle with operands already read from registers.
//
// Overview of operation
// - Byte and half-word positions count from the most significant end.
// - A signed byte takes bit 7 as its sign.
// - Byte load picks one byte of the memory word and widens it.
// - Sign select set sign-extends loaded byte or half-word, clear zero-extends.
// - Byte store puts source low byte into the chosen memory byte lane.
// - Extract byte replaces destination low byte with the pointed source byte.
// - Extract and insert byte choose position by the 2-bit byte pointer.
// - Insert byte writes source low byte into pointed destination byte, rest kept.
// - Compare any byte is true when any of four byte pairs match.
// - Half-word store puts source low 16 bits into the chosen half lane.
// - Extract half-word replaces destination low half, upper half kept.
// - Signed extract half-word fills upper 16 bits with the half's top bit.
// - Insert half-word writes source low half into one destination half.
// - Half-word extract and insert use only the pointer's upper bit.
// - Special register 133 is a second view of the pointer field.
// - Writes to ALU status or shift-count register set the funnel count.
// - Compare results are 1 or 0 in bit 31, other bits zero.
// - Conditional branches look only at bit 31 of their operand.
// - An 8-bit immediate may replace the source operand directly.
// - Low constant loads 16 bits, upper 16 bits cleared.
// - High constant loads upper 16 bits, lower 16 bits kept.
// - Negative constant loads 16 bits, upper 16 bits set.
`timescale 1ns/1ps
`default_nettype none

module subword_datapath
    import subword_pkg::*;
#(
    parameter int DATA_BITS = WORD_BITS
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Decoded instruction
    input wire dp_request_t REQ_I,
    // Special register moves
    input wire sr_request_t SR_I,
    // Results
    output dp_result_t RESULT_O,
    output logic [31:0] SR_RDATA_O,
    output logic [1:0] BYTE_POINTER_O
);

    // Datapath is built for one word width only
    if (DATA_BITS != WORD_BITS) begin : g_width_check
        $error("subword_datapath supports only 32-bit words");
    end

    dp_state_t st;
    dp_state_t next_st;

    // Byte selected by a big-endian lane index
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
        logic [7:0] b;
        b = 8'h00;
        case (lane)
            2'h0: b = w[31:24];
            2'h1: b = w[23:16];
            2'h2: b = w[15:8];
            default: b = w[7:0];
        endcase
        return b;
    endfunction : byte_of

    // Word with one big-endian byte lane replaced
    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        case (lane)
            2'h0: r[31:24] = b;
            2'h1: r[23:16] = b;
            2'h2: r[15:8] = b;
            default: r[7:0] = b;
        endcase
        return r;
    endfunction : put_byte

    // Half-word selected by the upper index bit
    function automatic logic [15:0] half_of(input logic [31:0] w, input logic upper_bit);
        return upper_bit ? w[15:0] : w[31:16];
    endfunction : half_of

    // One-hot lane enable for a big-endian byte index
    function automatic logic [3:0] lane_mask(input logic [1:0] lane);
        return 4'h8 >> lane;
    endfunction : lane_mask

    // Compute next state from the request and special register moves
    always_comb begin
        logic [31:0] src;
        logic [7:0] b;
        logic [15:0] h;
        logic any_eq;
        src = 32'h0;
        b = 8'h00;
        h = 16'h0000;
        any_eq = 1'b0;
        next_st = st;
        next_st.res.valid = 1'b0;
        next_st.res.branch_taken = 1'b0;
        next_st.res.store_lanes = 4'h0;
        // Short immediate replaces the source register
        src = REQ_I.use_imm8 ? {24'h000000, REQ_I.imm8} : REQ_I.src_value;
        if (REQ_I.valid) begin
            next_st.res.valid = 1'b1;
            case (REQ_I.op)
                OP_LOAD_BYTE: begin
                    b = byte_of(REQ_I.mem_word, REQ_I.addr_low);
                    next_st.res.data = REQ_I.sign_extend_select ? {{24{b[7]}}, b}
                                                                : {24'h000000, b};
                end
                OP_LOAD_HALF: begin
                    h = half_of(REQ_I.mem_word, REQ_I.addr_low[1]);
                    next_st.res.data = REQ_I.sign_extend_select ? {{16{h[15]}}, h}
                                                                : {16'h0000, h};
                end
                OP_STORE_BYTE: begin
                    next_st.res.store_word = put_byte(32'h0, REQ_I.addr_low, src[7:0]);
                    next_st.res.store_lanes = lane_mask(REQ_I.addr_low);
                end
                OP_STORE_HALF: begin
                    next_st.res.store_word = REQ_I.addr_low[1] ? {16'h0000, src[15:0]}
                                                               : {src[15:0], 16'h0000};
                    next_st.res.store_lanes = REQ_I.addr_low[1] ? 4'h3 : 4'hc;
                end
                OP_EXTRACT_BYTE: begin
                    next_st.res.data = {REQ_I.dest_value[31:8], byte_of(src, st.byte_pointer)};
                end
                OP_INSERT_BYTE: begin
                    next_st.res.data = put_byte(REQ_I.dest_value, st.byte_pointer, src[7:0]);
                end
                OP_COMPARE_ANY_BYTE: begin
                    for (int i = 0; i < LANES; i++) begin
                        any_eq = any_eq | (byte_of(REQ_I.dest_value, 2'(i)) == byte_of(src, 2'(i)));
                    end
                    next_st.res.data = any_eq ? BOOL_TRUE : BOOL_FALSE;
                end
                OP_EXTRACT_HALF: begin
                    h = half_of(src, st.byte_pointer[1]);
                    next_st.res.data = {REQ_I.dest_value[31:16], h};
                end
                OP_EXTRACT_HALF_S: begin
                    h = half_of(src, st.byte_pointer[1]);
                    next_st.res.data = {{16{h[15]}}, h};
                end
                OP_INSERT_HALF: begin
                    next_st.res.data = st.byte_pointer[1] ? {REQ_I.dest_value[31:16], src[15:0]}
                                                          : {src[15:0], REQ_I.dest_value[15:0]};
                end
                OP_LOAD_LOW_IMM: next_st.res.data = {16'h0000, REQ_I.imm16};
                OP_LOAD_HIGH_IMM: next_st.res.data = {REQ_I.imm16, REQ_I.dest_value[15:0]};
                OP_LOAD_NEG_IMM: next_st.res.data = {16'hffff, REQ_I.imm16};
                OP_BRANCH_COND: next_st.res.branch_taken = src[31];
                default: next_st.res.valid = 1'b0;
            endcase
            // Sign select on any byte or half-word load or store forces the pointer to the last byte
            if (REQ_I.sign_extend_select && (REQ_I.op inside {OP_LOAD_BYTE, OP_LOAD_HALF,
                                                              OP_STORE_BYTE, OP_STORE_HALF})) begin
                next_st.byte_pointer = BP_SIGN_SET;
            end
        end
        // Special register writes; a pointer or status move in the same cycle overrides sign select
        if (SR_I.write) begin
            if (SR_I.number == SR_ALU_STATUS) begin
                next_st.byte_pointer = SR_I.wdata[ALU_BP_LSB +: BP_BITS];
                next_st.funnel_shift_count = SR_I.wdata[ALU_FC_LSB +: FC_BITS];
            end else if (SR_I.number == SR_BYTE_POINTER) begin
                next_st.byte_pointer = SR_I.wdata[BP_BITS-1:0];
            end else if (SR_I.number == SR_FUNNEL_COUNT) begin
                next_st.funnel_shift_count = SR_I.wdata[FC_BITS-1:0];
            end
        end
        // Special register reads, answered one cycle later
        if (SR_I.read) begin
            if (SR_I.number == SR_ALU_STATUS) begin
                next_st.sr_rdata = {25'h0, st.byte_pointer, st.funnel_shift_count};
            end else if (SR_I.number == SR_BYTE_POINTER) begin
                next_st.sr_rdata = {30'h0, st.byte_pointer};
            end else if (SR_I.number == SR_FUNNEL_COUNT) begin
                next_st.sr_rdata = {27'h0, st.funnel_shift_count};
            end else begin
                next_st.sr_rdata = 32'h0;
            end
        end
    end

    // State register
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            st <= '{byte_pointer: BP_RESET, funnel_shift_count: FC_RESET, res: '0, sr_rdata: 32'h0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign RESULT_O = st.res;
    assign SR_RDATA_O = st.sr_rdata;
    assign BYTE_POINTER_O = st.byte_pointer;

    // Checks of the datapath
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    logic past_ok;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            past_ok <= 1'b0;
        end else begin
            past_ok <= 1'b1;
        end
    end

    a_load_byte_signed: assert property (REQ_I.valid && REQ_I.op == OP_LOAD_BYTE && REQ_I.sign_extend_select
        |=> RESULT_O.data[31:8] == {24{RESULT_O.data[7]}}
            && RESULT_O.data[7:0] == byte_of($past(REQ_I.mem_word), $past(REQ_I.addr_low)))
        else $error("signed byte load not sign-extended");

    a_load_byte_zero: assert property (REQ_I.valid && REQ_I.op == OP_LOAD_BYTE && !REQ_I.sign_extend_select
        |=> RESULT_O.data[31:8] == 24'h0 && RESULT_O.valid)
        else $error("unsigned byte load not zero-extended");

    a_store_byte_lane: assert property (REQ_I.valid && REQ_I.op == OP_STORE_BYTE && !REQ_I.use_imm8
        |=> byte_of(RESULT_O.store_word, $past(REQ_I.addr_low)) == $past(REQ_I.src_value[7:0])
            && RESULT_O.store_lanes == lane_mask($past(REQ_I.addr_low)))
        else $error("byte store lane wrong");

    a_extract_byte_keep: assert property (REQ_I.valid && REQ_I.op == OP_EXTRACT_BYTE
        |=> RESULT_O.data[31:8] == $past(REQ_I.dest_value[31:8]))
        else $error("extract byte disturbed upper bits");

    // Source operand as the checks see it, short immediate zero-extended
    logic [31:0] chk_src;
    assign chk_src = REQ_I.use_imm8 ? {24'h000000, REQ_I.imm8} : REQ_I.src_value;

    a_compare_bool: assert property (REQ_I.valid && REQ_I.op == OP_COMPARE_ANY_BYTE
        |=> RESULT_O.data[30:0] == 31'h0
            && RESULT_O.data[31] == $past(REQ_I.dest_value[31:24] == chk_src[31:24]
                || REQ_I.dest_value[23:16] == chk_src[23:16]
                || REQ_I.dest_value[15:8] == chk_src[15:8]
                || REQ_I.dest_value[7:0] == chk_src[7:0]))
        else $error("compare result not boolean");

    a_half_signed_fill: assert property (REQ_I.valid && REQ_I.op == OP_EXTRACT_HALF_S
        |=> RESULT_O.data[31:16] == {16{RESULT_O.data[15]}})
        else $error("signed half extract fill wrong");

    a_insert_half_keep: assert property (REQ_I.valid && REQ_I.op == OP_INSERT_HALF && !SR_I.write
        |=> (st.byte_pointer[1] ? RESULT_O.data[31:16] == $past(REQ_I.dest_value[31:16])
                                : RESULT_O.data[15:0] == $past(REQ_I.dest_value[15:0])))
        else $error("insert half overwrote wrong half");

    a_const_forms: assert property (REQ_I.valid && REQ_I.op inside {OP_LOAD_LOW_IMM, OP_LOAD_NEG_IMM}
        |=> RESULT_O.data[15:0] == $past(REQ_I.imm16)
            && RESULT_O.data[31:16] == ($past(REQ_I.op) == OP_LOAD_NEG_IMM ? 16'hffff : 16'h0000))
        else $error("constant upper half wrong");

    a_high_const: assert property (REQ_I.valid && REQ_I.op == OP_LOAD_HIGH_IMM
        |=> RESULT_O.data == {$past(REQ_I.imm16), $past(REQ_I.dest_value[15:0])})
        else $error("high constant wrong");

    a_bp_view: assert property (SR_I.write && SR_I.number == SR_ALU_STATUS ##1 SR_I.read
        && SR_I.number == SR_BYTE_POINTER && !SR_I.write
        |=> SR_RDATA_O == {30'h0, $past(SR_I.wdata[ALU_BP_LSB +: BP_BITS], 2)})
        else $error("pointer view differs from status field");

    a_fc_only: assert property (SR_I.write && SR_I.number == SR_FUNNEL_COUNT && past_ok
        |=> st.byte_pointer == $past((REQ_I.valid && REQ_I.sign_extend_select
                && (REQ_I.op inside {OP_LOAD_BYTE, OP_LOAD_HALF, OP_STORE_BYTE, OP_STORE_HALF}))
                ? BP_SIGN_SET : st.byte_pointer)
            && st.funnel_shift_count == $past(SR_I.wdata[FC_BITS-1:0]))
        else $error("shift count write wrong");

    a_branch_msb: assert property (REQ_I.valid && REQ_I.op == OP_BRANCH_COND
        |=> RESULT_O.branch_taken == $past(REQ_I.use_imm8 ? 1'b0 : REQ_I.src_value[31]))
        else $error("branch decision not from bit 31");

    c_compare_true: cover property (REQ_I.valid && REQ_I.op == OP_COMPARE_ANY_BYTE ##1 RESULT_O.data[31]);
    c_bp_write_read: cover property (SR_I.write && SR_I.number == SR_BYTE_POINTER ##1 SR_I.read);
    c_insert_after_sign: cover property (REQ_I.valid && REQ_I.sign_extend_select ##1 REQ_I.op == OP_INSERT_BYTE);

endmodule : subword_datapath

`default_nettype wire

// ===== verif/subword_decoder_model.sv
// Partner model: the instruction decoder and register read ports feeding the datapath.
// Assumes the bench calls its tasks; every change lands at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module subword_decoder_model
    import subword_pkg::*;
(
    // Clock
    input wire logic CLK_SYS_I,
    // Requests toward the datapath
    output var dp_request_t REQ_O,
    output var sr_request_t SR_O
);
    // Quiet request lines at time zero
    initial begin
        REQ_O = '0;
        SR_O = '0;
    end

    // Present one request from the next falling edge; it stays until the next issue or idle call
    task automatic issue(input dp_request_t r, input sr_request_t s);
        @(negedge CLK_SYS_I);
        REQ_O = r;
        SR_O = s;
    endtask : issue

    // Idle cycle: strobes low, operand lines flip so stale values never look valid
    task automatic idle();
        dp_request_t t;
        sr_request_t u;
        @(negedge CLK_SYS_I);
        t = ~REQ_O;
        t.valid = 1'b0;
        u = ~SR_O;
        u.write = 1'b0;
        u.read = 1'b0;
        REQ_O = t;
        SR_O = u;
    endtask : idle
endmodule : subword_decoder_model

`default_nettype wire

// ===== verif/test_byte_halfword_const_datapath.sv
// Self-checking bench for the sub-word datapath against an integer reference model.
// Assumes the decoder model drives all requests; results are checked at falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module test_byte_halfword_const_datapath
    import subword_pkg::*;
;
    // Bench signals and reference state
    logic CLK_SYS_I;
    logic RST_I;
    dp_request_t req, r;
    sr_request_t sr, s;
    dp_result_t res;
    logic [31:0] sr_rdata, m, n, e_data, e_sw, e_sr;
    logic [31:0] seed = 32'h0000_b486;
    logic [1:0] bp_out, bp;
    logic [4:0] fc;
    logic [3:0] e_ln;
    logic pend, pend_sr, e_valid, e_chk, e_br;
    logic [7:0] nums [5] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h00};
    int bad_count = 0;
    int cmp_count = 0;
    int i;

    subword_datapath #(.DATA_BITS(WORD_BITS)) i_subword_datapath (
        .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REQ_I(req), .SR_I(sr),
        .RESULT_O(res), .SR_RDATA_O(sr_rdata), .BYTE_POINTER_O(bp_out)
    );
    subword_decoder_model i_subword_decoder_model (.CLK_SYS_I(CLK_SYS_I), .REQ_O(req), .SR_O(sr));

    // 25 MHz clock
    initial begin
        CLK_SYS_I = 1'b0;
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end

    // Hang guard
    initial begin
        #4_000_000;
        bad_count++;
        $display("BAD timeout exp end got none");
        finish_test();
    end

    // Fixed-seed random source
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    // Compare outputs of the previous request with the model
    task automatic check();
        if (pend) begin
            `CHK("valid", e_valid, res.valid)
            if (e_chk) `CHK("data", e_data, res.data)
            `CHK("store", e_sw, res.store_word)
            `CHK("lanes", e_ln, res.store_lanes)
            `CHK("branch", e_br, res.branch_taken)
        end
        if (pend_sr) `CHK("sr_read", e_sr, sr_rdata)
        `CHK("pointer", bp, bp_out)
    endtask : check

    // Issue one request, check the last one, and predict this one
    task automatic step(input dp_request_t q, input sr_request_t t);
        logic [31:0] v;
        logic [31:0] d;
        logic [7:0] b;
        logic [15:0] h;
        logic [15:0] hs;
        logic [3:0] eq;
        int p;
        i_subword_decoder_model.issue(q, t);
        check();
        v = q.use_imm8 ? {24'h0, q.imm8} : q.src_value;
        d = q.dest_value;
        p = 8 * (3 - q.addr_low);
        b = q.mem_word[p +: 8];
        h = q.addr_low[1] ? q.mem_word[15:0] : q.mem_word[31:16];
        hs = bp[1] ? v[15:0] : v[31:16];
        for (int k = 0; k < 4; k++)
            eq[k] = d[8 * k +: 8] == v[8 * k +: 8];
        pend = 1'b1;
        e_valid = q.valid && q.op != OP_NONE;
        e_chk = e_valid;
        e_ln = 4'h0;
        e_br = 1'b0;
        if (e_valid) begin
            case (q.op)
                OP_LOAD_BYTE: e_data = q.sign_extend_select ? {{24{b[7]}}, b} : {24'h0, b};
                OP_LOAD_HALF: e_data = q.sign_extend_select ? {{16{h[15]}}, h} : {16'h0, h};
                OP_STORE_BYTE: begin
                    e_chk = 1'b0;
                    e_sw = {24'h0, v[7:0]} << p;
                    e_ln = 4'h1 << (3 - q.addr_low);
                end
                OP_STORE_HALF: begin
                    e_chk = 1'b0;
                    e_sw = q.addr_low[1] ? {16'h0, v[15:0]} : {v[15:0], 16'h0};
                    e_ln = q.addr_low[1] ? 4'h3 : 4'hc;
                end
                OP_EXTRACT_BYTE: e_data = {d[31:8], v[8 * (3 - bp) +: 8]};
                OP_INSERT_BYTE: begin
                    e_data = d;
                    e_data[8 * (3 - bp) +: 8] = v[7:0];
                end
                OP_COMPARE_ANY_BYTE: e_data = |eq ? BOOL_TRUE : BOOL_FALSE;
                OP_EXTRACT_HALF: e_data = {d[31:16], hs};
                OP_EXTRACT_HALF_S: e_data = {{16{hs[15]}}, hs};
                OP_INSERT_HALF: e_data = bp[1] ? {d[31:16], v[15:0]} : {v[15:0], d[15:0]};
                OP_LOAD_LOW_IMM: e_data = {16'h0000, q.imm16};
                OP_LOAD_HIGH_IMM: e_data = {q.imm16, d[15:0]};
                OP_LOAD_NEG_IMM: e_data = {16'hffff, q.imm16};
                OP_BRANCH_COND: begin
                    e_chk = 1'b0;
                    e_br = v[31];
                end
                default: e_chk = 1'b0;
            endcase
        end
        // Read sees state before this edge; then sign-select, then a same-cycle write wins
        if (t.read) begin
            pend_sr = 1'b1;
            e_sr = 32'h0;
            if (t.number == SR_BYTE_POINTER) e_sr = {30'h0, bp};
            if (t.number == SR_ALU_STATUS) e_sr = {25'h0, bp, fc};
            if (t.number == SR_FUNNEL_COUNT) e_sr = {27'h0, fc};
        end
        if (e_valid && q.op inside {[OP_LOAD_BYTE:OP_STORE_HALF]} && q.sign_extend_select) bp = BP_SIGN_SET;
        if (t.write && t.number == SR_BYTE_POINTER) bp = t.wdata[1:0];
        if (t.write && t.number == SR_ALU_STATUS) begin
            bp = t.wdata[ALU_BP_LSB +: BP_BITS];
            fc = t.wdata[ALU_FC_LSB +: FC_BITS];
        end
        if (t.write && t.number == SR_FUNNEL_COUNT) fc = t.wdata[4:0];
    endtask : step

    // One idle cycle to collect the last result
    task automatic flush();
        i_subword_decoder_model.idle();
        check();
        pend = 1'b0;
    endtask : flush

    // Reset for three cycles and check the cleared outputs
    task automatic do_reset();
        i_subword_decoder_model.idle();
        RST_I = 1'b1;
        repeat (3) @(negedge CLK_SYS_I);
        RST_I = 1'b0;
        bp = BP_RESET;
        fc = FC_RESET;
        e_sw = 32'h0;
        pend = 1'b0;
        pend_sr = 1'b0;
        `CHK("reset_result", '0, res)
        `CHK("reset_sr", 32'h0, sr_rdata)
        `CHK("reset_pointer", BP_RESET, bp_out)
        $display("test reset done");
    endtask : do_reset

    // Verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        RST_I = 1'b1;
        do_reset();
        r = '0;
        s = '0;
        r.valid = 1'b1;
        r.op = OP_LOAD_BYTE;
        r.addr_low = 2'h1;
        r.sign_extend_select = 1'b1;
        r.mem_word = 32'h1280_3456;
        s.write = 1'b1;
        s.number = SR_BYTE_POINTER;
        s.wdata = 32'h0000_0001;
        step(r, s);
        `CHK("walk_load", 32'hffff_ff80, e_data)
        r.valid = 1'b0;
        s.wdata = 32'h0000_0002;
        step(r, s);
        s.write = 1'b0;
        s.read = 1'b1;
        s.number = SR_ALU_STATUS;
        step(r, s);
        // Status write, then read back through the pointer view
        s.write = 1'b1;
        s.read = 1'b0;
        s.wdata = 32'h0000_0075;
        step(r, s);
        s.write = 1'b0;
        s.read = 1'b1;
        s.number = SR_BYTE_POINTER;
        step(r, s);
        flush();
        `CHK("walk_view", 32'h0000_0003, e_sr)
        $display("test walk done");
        // Random back-to-back sweep over every operation, with a mid-run reset
        for (i = 0; i < 450; i++) begin
            if (i == 225) begin
                flush();
                do_reset();
            end
            m = xorshift();
            n = xorshift();
            r.valid = m[31] | m[30];
            r.op = dp_op_t'(i % 15);
            r.dest_value = xorshift();
            r.src_value = r.dest_value ^ (n & {{8{m[0] | m[16]}}, {8{m[1] | m[17]}}, {8{m[2] | m[18]}},
                {8{m[3] | m[19]}}});
            r.use_imm8 = m[4] && r.op > OP_STORE_HALF;
            r.imm8 = m[15:8];
            r.imm16 = n[15:0] ^ m[29:14];
            r.addr_low = m[6:5];
            r.sign_extend_select = m[7];
            r.mem_word = xorshift();
            s.write = n[20] & n[21];
            s.read = n[22];
            s.number = nums[n[26:24] % 5];
            s.wdata = {n[31:27], m[26:0]};
            step(r, s);
        end
        flush();
        $display("test sweep done");
        finish_test();
    end
endmodule : test_byte_halfword_const_datapath

`default_nettype wire
